// ---- rtl/plal_consts.svh ----
// Constants for the partition lobby arming logic
// Summary of operation
// - Each of two areas holds its own armed or disarmed state.
// - Active area count is one or two; areas beyond it are unused.
// - Each keypad belongs to one area or to pseudo-area three (status station).
// - Each zone belongs to one area; shown only on that area's keypads.
// - Per user: permitted area set and authority level per area.
// - One command arms/disarms several areas only with collective flag set.
// - Cross-area log-on from an area keypad allowed only if target area's enable is set.
// - One area is designated lobby; only it follows other areas.
// - First dependent area disarming also disarms the lobby.
// - Lobby arm refused while any dependent area is disarmed.
// - Arming a dependent area without auto-arm flag starts no lobby attempt.
// - Arming an area with dependency and auto-arm flags attempts lobby arming.
// - Auto lobby attempt fails on lobby fault or disarmed dependent; flags failure.
// - Auto-arm flag without dependency flag is a rejected configuration.
// - Collective users choose areas explicitly; no automatic lobby following.
// - Collective lobby-only arm with disarmed dependent leaves lobby disarmed, flags failure.
// - Non-collective keypad requests apply automatic lobby behaviour.
// - Quick-arm, keyswitch and wireless sources also apply lobby behaviour.
// - Remote or scheduled commands never make the lobby follow.
`ifndef PLAL_CONSTS_SVH
`define PLAL_CONSTS_SVH
`define PLAL_NUM_AREAS 2
`define PLAL_NUM_USERS 8
`define PLAL_AUTH_W 3
`define PLAL_KEYPADS 8
`define PLAL_ZONES 16
`define PLAL_MASTER_AREA 2'h3
`define PLAL_NO_LOBBY 2'h0
`define PLAL_ARMED_RST 2'h0
`endif

// ---- rtl/plal_pkg.sv ----
// Types for the partition lobby arming logic
package plal_pkg;
	typedef enum logic [2:0] {
		PLAL_SRC_KEYPAD,
		PLAL_SRC_QUICK,
		PLAL_SRC_KEYSWITCH,
		PLAL_SRC_WL_BUTTON,
		PLAL_SRC_WL_KEYPAD,
		PLAL_SRC_REMOTE,
		PLAL_SRC_SCHEDULE
	} plal_src_t;
	typedef enum logic [1:0] {
		PLAL_RES_OK,
		PLAL_RES_DENIED,
		PLAL_RES_LOBBY_FAIL
	} plal_res_t;
endpackage

// ---- rtl/plal_access_check.sv ----
// Per-user access lookup: area rights, authority and collective flag
`timescale 1ns/100ps
`include "plal_consts.svh"
module plal_access_check #(
	parameter int NUM_USERS = `PLAL_NUM_USERS,
	parameter int AUTH_W = `PLAL_AUTH_W
)(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic cfg_we_i,
	input wire logic [$clog2(NUM_USERS)-1:0] cfg_user_i,
	input wire logic [1:0] cfg_areas_i,
	input wire logic [2*AUTH_W-1:0] cfg_auth_i,
	input wire logic cfg_collective_i,
	input wire logic [$clog2(NUM_USERS)-1:0] user_i,
	output logic [1:0] areas_o,
	output logic [2*AUTH_W-1:0] auth_o,
	output logic collective_o
);
	logic [1:0] area_mem [NUM_USERS];
	logic [2*AUTH_W-1:0] auth_mem [NUM_USERS];
	logic [NUM_USERS-1:0] coll_reg;

	// ----------------------------------------
	// User table
	// ----------------------------------------
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			for (int i = 0; i < NUM_USERS; i++)
			begin
				area_mem[i] <= 2'h0;
				auth_mem[i] <= '0;
			end
		end
		else if (cfg_we_i)
		begin
			area_mem[cfg_user_i] <= cfg_areas_i;
			auth_mem[cfg_user_i] <= cfg_auth_i;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			coll_reg <= '0;
		else if (cfg_we_i)
			coll_reg[cfg_user_i] <= cfg_collective_i;
	end

	assign areas_o = area_mem[user_i];
	assign auth_o = auth_mem[user_i];
	assign collective_o = coll_reg[user_i];
endmodule

// ---- rtl/plal_lobby_arm.sv ----
// Two-area arming state manager with common lobby following
`timescale 1ns/100ps
`include "plal_consts.svh"
module plal_lobby_arm #(
	parameter int NUM_USERS = `PLAL_NUM_USERS,
	parameter int AUTH_W = `PLAL_AUTH_W,
	parameter int KEYPADS = `PLAL_KEYPADS,
	parameter int ZONES = `PLAL_ZONES
)(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [1:0] CFG_AREA_COUNT_I,
	input wire logic [1:0] CFG_LOBBY_AREA_I,
	input wire logic [1:0] CFG_DEPENDS_I,
	input wire logic [1:0] CFG_AUTO_ARM_I,
	input wire logic [1:0] CFG_LOGON_EN_I,
	input wire logic [2*KEYPADS-1:0] CFG_KEYPAD_AREA_I,
	input wire logic [ZONES-1:0] CFG_ZONE_AREA_I,
	input wire logic CFG_USER_WE_I,
	input wire logic [$clog2(NUM_USERS)-1:0] CFG_USER_I,
	input wire logic [1:0] CFG_USER_AREAS_I,
	input wire logic [2*AUTH_W-1:0] CFG_USER_AUTH_I,
	input wire logic CFG_USER_COLLECTIVE_I,
	input wire logic [ZONES-1:0] ZONE_FAULT_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_ARM_I,
	input wire logic [1:0] REQ_AREAS_I,
	input wire logic [$clog2(NUM_USERS)-1:0] REQ_USER_I,
	input wire logic [$clog2(KEYPADS)-1:0] REQ_KEYPAD_I,
	input wire plal_pkg::plal_src_t REQ_SRC_I,
	output logic [1:0] ARMED_O,
	output logic [1:0] AREA_ACTIVE_O,
	output logic DONE_O,
	output plal_pkg::plal_res_t RESULT_O,
	output logic LOBBY_ARM_FAILURE_INDICATION_O,
	output logic CFG_ERROR_O,
	output logic [ZONES-1:0] ZONE_SHOWN_O,
	output logic STATUS_STATION_O,
	output logic [2*AUTH_W-1:0] USER_AUTH_O
);
	import plal_pkg::*;

	logic [1:0] armed_reg;
	logic [1:0] active_reg;
	logic done_reg;
	plal_res_t result_reg;
	logic fail_reg;
	logic cfg_err_reg;
	logic [ZONES-1:0] shown_reg;
	logic station_reg;
	logic [2*AUTH_W-1:0] auth_reg;
	logic [1:0] user_areas;
	logic [2*AUTH_W-1:0] user_auth;
	logic user_coll;

	logic [1:0] armed_next;
	plal_res_t result_next;
	logic fail_next;

	plal_access_check #(
		.NUM_USERS(NUM_USERS),
		.AUTH_W(AUTH_W)
	) u_access (
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.cfg_we_i(CFG_USER_WE_I),
		.cfg_user_i(CFG_USER_I),
		.cfg_areas_i(CFG_USER_AREAS_I),
		.cfg_auth_i(CFG_USER_AUTH_I),
		.cfg_collective_i(CFG_USER_COLLECTIVE_I),
		.user_i(REQ_USER_I),
		.areas_o(user_areas),
		.auth_o(user_auth),
		.collective_o(user_coll)
	);

	// Area index of a keypad; code three marks a status station
	function automatic logic [1:0] keypad_area(input logic [$clog2(KEYPADS)-1:0] k);
		keypad_area = CFG_KEYPAD_AREA_I[2*k +: 2];
	endfunction

	// Lobby index as a one-hot mask; area one may not be lobby
	function automatic logic [1:0] lobby_mask(input logic [1:0] sel);
		lobby_mask = (sel == 2'h2) ? 2'b10 : 2'b00;
	endfunction

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	logic [1:0] active;
	logic [1:0] lobby;
	logic [1:0] deps;
	logic [1:0] autos;
	logic lobby_fault;
	always_comb
	begin
		active = (CFG_AREA_COUNT_I == 2'h2) ? 2'b11 : 2'b01;
		lobby = lobby_mask(CFG_LOBBY_AREA_I) & active;
		deps = CFG_DEPENDS_I & active & ~lobby;
		autos = CFG_AUTO_ARM_I & deps;
		lobby_fault = 1'b0;
		for (int z = 0; z < ZONES; z++)
			if (lobby[1] && CFG_ZONE_AREA_I[z] && ZONE_FAULT_I[z])
				lobby_fault = 1'b1;
	end

	// ----------------------------------------
	// Request evaluation
	// ----------------------------------------
	logic [1:0] kp_area;
	logic [1:0] target;
	logic permitted;
	logic auto_mode;
	always_comb
	begin
		kp_area = keypad_area(REQ_KEYPAD_I);
		target = REQ_AREAS_I & active & user_areas;
		armed_next = armed_reg;
		result_next = PLAL_RES_OK;
		fail_next = 1'b0;
		permitted = 1'b1;
		// Several areas in one command need the collective flag
		if (target != REQ_AREAS_I || target == 2'b00)
			permitted = 1'b0;
		if (!user_coll && target == 2'b11)
			permitted = 1'b0;
		// Cross-area log-on from a keypad of another area
		if (REQ_SRC_I == PLAL_SRC_KEYPAD && kp_area != `PLAL_MASTER_AREA)
			for (int a = 0; a < 2; a++)
				if (target[a] && kp_area != 2'(a) && !CFG_LOGON_EN_I[a])
					permitted = 1'b0;
		auto_mode = !user_coll && REQ_SRC_I != PLAL_SRC_REMOTE
			&& REQ_SRC_I != PLAL_SRC_SCHEDULE;
		if (!permitted)
			result_next = PLAL_RES_DENIED;
		else if (!REQ_ARM_I)
		begin
			armed_next = armed_reg & ~target;
			// First dependent area going down drags the lobby with it
			if (auto_mode && |(target & deps & armed_reg))
				armed_next = armed_next & ~lobby;
		end
		else
		begin
			armed_next = armed_reg | (target & ~lobby);
			if (|(target & lobby))
			begin
				if (|(deps & ~armed_next))
				begin
					fail_next = 1'b1;
					result_next = PLAL_RES_LOBBY_FAIL;
				end
				else
					armed_next = armed_next | lobby;
			end
			else if (auto_mode && |(target & autos) && |lobby)
			begin
				if (lobby_fault || |(deps & ~armed_next))
				begin
					fail_next = 1'b1;
					result_next = PLAL_RES_LOBBY_FAIL;
				end
				else
					armed_next = armed_next | lobby;
			end
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			armed_reg <= `PLAL_ARMED_RST;
		else if (REQ_VALID_I)
			armed_reg <= armed_next & active;
		else
			armed_reg <= armed_reg & active;
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			done_reg <= 1'b0;
			result_reg <= PLAL_RES_OK;
			fail_reg <= 1'b0;
			auth_reg <= '0;
		end
		else
		begin
			done_reg <= REQ_VALID_I;
			if (REQ_VALID_I)
			begin
				result_reg <= result_next;
				fail_reg <= fail_next;
				auth_reg <= user_auth;
			end
			else
				fail_reg <= 1'b0;
		end
	end

	// Rejected flag combination stays visible while configured
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			cfg_err_reg <= 1'b0;
		else
			cfg_err_reg <= |(CFG_AUTO_ARM_I & ~CFG_DEPENDS_I);
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			active_reg <= 2'b00;
			shown_reg <= '0;
			station_reg <= 1'b0;
		end
		else
		begin
			active_reg <= active;
			station_reg <= (kp_area == `PLAL_MASTER_AREA);
			for (int z = 0; z < ZONES; z++)
				shown_reg[z] <= (kp_area == {1'b0, CFG_ZONE_AREA_I[z]})
					&& active[CFG_ZONE_AREA_I[z]];
		end
	end

	assign ARMED_O = armed_reg;
	assign AREA_ACTIVE_O = active_reg;
	assign DONE_O = done_reg;
	assign RESULT_O = result_reg;
	assign LOBBY_ARM_FAILURE_INDICATION_O = fail_reg;
	assign CFG_ERROR_O = cfg_err_reg;
	assign ZONE_SHOWN_O = shown_reg;
	assign STATUS_STATION_O = station_reg;
	assign USER_AUTH_O = auth_reg;
endmodule

// ---- tb/plal_lobby_arm_asserts.sv ----
// Port-level assertions for the lobby arming block
`timescale 1ns/100ps
module plal_chk (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [1:0] CFG_AREA_COUNT_I,
	input wire logic [1:0] CFG_LOBBY_AREA_I,
	input wire logic [1:0] CFG_DEPENDS_I,
	input wire logic [1:0] CFG_AUTO_ARM_I,
	input wire logic REQ_VALID_I,
	input wire logic [1:0] ARMED_O,
	input wire logic [1:0] AREA_ACTIVE_O,
	input wire logic DONE_O,
	input wire plal_pkg::plal_res_t RESULT_O,
	input wire logic LOBBY_ARM_FAILURE_INDICATION_O,
	input wire logic CFG_ERROR_O
);
	import plal_pkg::*;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	a_done_follows: assert property (REQ_VALID_I |=> DONE_O) else $error("no done");
	a_reset_disarm: assert property ($past(RST_I) |-> ARMED_O == 2'h0)
		else $error("armed after reset");
	a_state_held: assert property (!DONE_O |-> $stable(ARMED_O)) else $error("idle move");
	a_denied_keeps: assert property (DONE_O && RESULT_O == PLAL_RES_DENIED |->
		$stable(ARMED_O)) else $error("denied moved");
	a_fail_pulse: assert property (LOBBY_ARM_FAILURE_INDICATION_O |-> DONE_O)
		else $error("stray failure");
	a_lobby_blocked: assert property ($rose(ARMED_O[1]) && $past(CFG_LOBBY_AREA_I) == 2'h2
		&& $past(CFG_DEPENDS_I[0]) |-> ARMED_O[0]) else $error("lobby early");
	a_active_count: assert property (!$past(RST_I) |->
		AREA_ACTIVE_O == ($past(CFG_AREA_COUNT_I) == 2'h2 ? 2'h3 : 2'h1)) else $error("active");
	a_cfg_reject: assert property (!$past(RST_I) |-> CFG_ERROR_O ==
		(($past(CFG_AUTO_ARM_I) & ~$past(CFG_DEPENDS_I)) != 2'h0)) else $error("cfg error");
	c_fail: cover property (LOBBY_ARM_FAILURE_INDICATION_O);
	c_denied: cover property (DONE_O && RESULT_O == PLAL_RES_DENIED);
	c_follow: cover property ($rose(ARMED_O[1]) && $rose(ARMED_O[0]));
endmodule
bind plal_lobby_arm plal_chk i_chk (.*);

// ---- tb/plal_keypad_model.sv ----
// Keypad side model issuing arm and disarm requests
`timescale 1ns/100ps
module plal_keypad_model (
	input wire logic clk_i,
	output logic req_valid_o,
	output logic req_arm_o,
	output logic [1:0] req_areas_o,
	output logic [2:0] req_user_o,
	output logic [2:0] req_keypad_o,
	output plal_pkg::plal_src_t req_src_o
);
	import plal_pkg::*;
	initial
	begin
		{req_valid_o, req_arm_o, req_areas_o, req_user_o, req_keypad_o} = 9'h000;
		req_src_o = PLAL_SRC_KEYPAD;
	end
	task issue(logic a, logic [1:0] r, logic [2:0] u, logic [2:0] k, plal_src_t s);
		@(negedge clk_i);
		{req_arm_o, req_areas_o, req_user_o, req_keypad_o} = {a, r, u, k};
		req_src_o = s;
		req_valid_o = 1'b1;
		@(negedge clk_i);
		req_valid_o = 1'b0;
		// Flip released lines so stale data is never mistaken for a request
		{req_arm_o, req_areas_o, req_user_o, req_keypad_o} = ~{a, r, u, k};
	endtask
endmodule

// ---- tb/plal_lobby_arm_tb.sv ----
// Self-checking bench for the lobby arming block
`timescale 1ns/100ps
module plal_lobby_arm_tb;
	import plal_pkg::*;
	logic CLK_I = 0, RST_I = 1, CFG_USER_WE_I = 0, CFG_USER_COLLECTIVE_I = 0;
	logic [1:0] CFG_AREA_COUNT_I = 2'h2, CFG_DEPENDS_I = 2'h1, CFG_AUTO_ARM_I = 2'h0;
	logic [1:0] CFG_LOGON_EN_I = 2'h3, CFG_USER_AREAS_I = 2'h3;
	logic [1:0] CFG_LOBBY_AREA_I = 2'h2;
	logic [15:0] CFG_ZONE_AREA_I = 16'h0002;
	logic [15:0] CFG_KEYPAD_AREA_I = 16'h0034, ZONE_FAULT_I = 16'h0000;
	logic [2:0] CFG_USER_I = 3'h0;
	logic [5:0] CFG_USER_AUTH_I = 6'h2A;
	wire REQ_VALID_I, REQ_ARM_I, DONE_O, LOBBY_ARM_FAILURE_INDICATION_O, CFG_ERROR_O;
	wire STATUS_STATION_O;
	wire [1:0] REQ_AREAS_I, ARMED_O, AREA_ACTIVE_O;
	wire [2:0] REQ_USER_I, REQ_KEYPAD_I;
	wire [5:0] USER_AUTH_O;
	wire [15:0] ZONE_SHOWN_O;
	wire plal_src_t REQ_SRC_I;
	wire plal_res_t RESULT_O;
	int fails = 0, samples_checked = 0;
	always #2.5 CLK_I = ~CLK_I;
	plal_lobby_arm i_dut (.*);
	plal_keypad_model i_kp (.clk_i(CLK_I), .req_valid_o(REQ_VALID_I), .req_arm_o(REQ_ARM_I),
		.req_areas_o(REQ_AREAS_I), .req_user_o(REQ_USER_I), .req_keypad_o(REQ_KEYPAD_I),
		.req_src_o(REQ_SRC_I));
	task chk(logic [5:0] got, logic [5:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task chk_zones(logic [15:0] got, logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: zones %h not %h", $time, got, exp);
		end
	endtask
	function logic [5:0] st();
		return {2'h0, DONE_O, LOBBY_ARM_FAILURE_INDICATION_O, ARMED_O};
	endfunction
	task rq(logic a, logic [1:0] r, logic [2:0] u = 3'h0, logic [2:0] k = 3'h0,
		plal_src_t s = PLAL_SRC_KEYPAD);
		i_kp.issue(a, r, u, k, s);
	endtask
	task stop_test;
		$display("checked %0d wrong %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task t_start;
		repeat (3) @(negedge CLK_I);
		RST_I = 0;
		chk({2'h0, AREA_ACTIVE_O, ARMED_O}, 6'h00);
		for (int i = 0; i < 2; i++)
		begin
			{CFG_USER_I, CFG_USER_COLLECTIVE_I, CFG_USER_WE_I} = {3'(i), 1'(i), 1'b1};
			@(negedge CLK_I);
		end
		CFG_USER_WE_I = 0;
		{CFG_AUTO_ARM_I, CFG_DEPENDS_I, CFG_AREA_COUNT_I} = 6'h11;
		@(negedge CLK_I);
		chk({3'h0, CFG_ERROR_O, AREA_ACTIVE_O}, 6'h05);
		{CFG_AUTO_ARM_I, CFG_DEPENDS_I, CFG_AREA_COUNT_I} = 6'h06;
		@(negedge CLK_I);
		chk({3'h0, CFG_ERROR_O, AREA_ACTIVE_O}, 6'h03);
		$display("t_start done");
	endtask
	task t_follow;
		rq(1, 2'h1);
		chk(st(), 6'h09);
		rq(0, 2'h1);
		rq(1, 2'h2);
		chk({4'h0, ARMED_O}, 6'h00);
		CFG_AUTO_ARM_I = 2'h1;
		rq(1, 2'h1);
		chk(st(), 6'h0B);
		rq(0, 2'h1);
		chk(st(), 6'h08);
		ZONE_FAULT_I = 16'h0002;
		rq(1, 2'h1);
		chk(st(), 6'h0D);
		ZONE_FAULT_I = 16'h0000;
		rq(0, 2'h1);
		$display("t_follow done");
	endtask
	task t_src;
		for (int i = 0; i < 7; i++)
		begin
			rq(1, 2'h1, 3'h0, 3'h0, plal_src_t'(i));
			chk(st(), i < 5 ? 6'h0B : 6'h09);
			rq(0, 2'h1);
		end
		rq(1, 2'h1);
		rq(0, 2'h1, 3'h0, 3'h0, PLAL_SRC_REMOTE);
		chk(st(), 6'h0A);
		rq(0, 2'h2);
		$display("t_src done");
	endtask
	task t_coll;
		rq(1, 2'h1, 3'h1);
		chk(st(), 6'h09);
		rq(1, 2'h3);
		chk({4'h0, RESULT_O}, 6'h01);
		rq(0, 2'h1, 3'h1);
		rq(1, 2'h2, 3'h1);
		chk(st(), 6'h0C);
		chk({4'h0, RESULT_O}, 6'h02);
		$display("t_coll done");
	endtask
	task t_logon;
		CFG_LOGON_EN_I = 2'h2;
		rq(1, 2'h1, 3'h0, 3'h1);
		chk({4'h0, RESULT_O}, 6'h01);
		chk(USER_AUTH_O, 6'h2A);
		CFG_LOGON_EN_I = 2'h1;
		rq(1, 2'h1, 3'h0, 3'h1);
		chk(st(), 6'h0B);
		$display("t_logon done");
	endtask
	task t_show;
		rq(0, 2'h1, 3'h0, 3'h1);
		chk(st(), 6'h08);
		chk_zones(ZONE_SHOWN_O, 16'h0002);
		chk({5'h0, STATUS_STATION_O}, 6'h00);
		rq(0, 2'h1);
		chk_zones(ZONE_SHOWN_O, 16'hFFFD);
		rq(0, 2'h2, 3'h0, 3'h2);
		chk({5'h0, STATUS_STATION_O}, 6'h01);
		chk_zones(ZONE_SHOWN_O, 16'h0000);
		CFG_AREA_COUNT_I = 2'h1;
		rq(1, 2'h2, 3'h0, 3'h1);
		chk({4'h0, RESULT_O}, 6'h01);
		chk_zones(ZONE_SHOWN_O, 16'h0000);
		$display("t_show done");
	endtask
	initial
	begin
		t_start();
		t_follow();
		t_src();
		t_coll();
		t_logon();
		t_show();
		stop_test();
	end
	initial
	begin
		#3000 fails++;
		stop_test();
	end
endmodule
